// *** verilog/ahpr_host_port.sv ***
`timescale 1ns/10ps
`default_nettype none
// Contract
// R1 - host pulses reset low at power-up
// R2 - high byte driven while clock high, float low
// R3 - next rising edge gives low byte, held
// R4 - support word writes, word/byte and repeat reads
// R5 - unused control bits are ignored
// R6 - trigger bit starts conversion after full write
// R7 - channel code decodes to inputs, 6-9 unused
// R8 - done flag set on completed conversion
// R9 - word write to command clears done flag
// R10 - other result high bits read zero
// R11 - result byte in low byte
// R12 - digital word shows shared pin levels
// R13 - digital word shows held channel code
// R14 - low digital bits 2^-3..2^-8 meaningless
// R15 - pointer home after chip select high cycle
// R16 - register pick selects result or digital word
// R17 - new command aborts running conversion
// R18 - reset held three clocks idles, floats, keeps result
// R19 - channel field in low nibble bits 2^-5..2^-8
module ahpr_host_port #(
  parameter int ACQ  = ahpr_pkg::ACQ_CYCLES,
  parameter int BITC = ahpr_pkg::BIT_CYCLES
) (
  input  wire logic                          clk,
  input  wire logic                          srst,
  input  wire logic                          bus_clk,
  input  wire logic                          cs_n,
  input  wire logic                          rd_wr_n,
  input  wire logic                          register_pick,
  input  wire logic                          dev_reset_n,
  input  wire logic [ahpr_pkg::BYTE_W-1:0]   data_in,
  output logic      [ahpr_pkg::BYTE_W-1:0]   data_out,
  output logic                               data_oe,
  input  wire logic [ahpr_pkg::PIN_N-1:0]    shared_input_pins,
  input  wire logic                          cmp_hi,
  output logic      [ahpr_pkg::MUX_N-1:0]    mux_sel,
  output logic                               sampling,
  output logic      [ahpr_pkg::BYTE_W-1:0]   trial_code
);
  import ahpr_pkg::*;

  ahpr_port_type     s_r, s_nxt;
  logic              bclk_rise, bclk_fall, core_done, core_busy;
  logic [BYTE_W-1:0] core_result;
  logic [15:0]       result_word, digital_word, sel_word;
  logic [MUX_N-1:0]  chan_hot;
  logic              rd_en, wr_en, in_reset, wr_done;

  ////////////////////////////////////////////////////////////////////////
  // bus clock edges and access qualifiers
  assign bclk_rise = bus_clk & ~s_r.bclk_q;
  assign bclk_fall = ~bus_clk & s_r.bclk_q;
  assign in_reset  = ~dev_reset_n;
  assign rd_en     = ~cs_n & rd_wr_n & ~in_reset;
  assign wr_en     = bclk_rise & ~cs_n & ~rd_wr_n & ~in_reset;
  assign wr_done   = wr_en & s_r.ptr_lo;

  // readable words; everything above the done flag reads zero
  always_comb begin
    result_word                  = '0;                           // R10
    result_word[BYTE_W+DONE_BIT] = s_r.done;                     // R8
    result_word[BYTE_W-1:0]      = s_r.result;                   // R11
    digital_word = '0;                                            // R14
    digital_word[BYTE_W+PIN_LSB +: PIN_N] = shared_input_pins;   // R12
    digital_word[BYTE_W +: CHAN_HI_W] =
      s_r.chan[CHAN_W-1 -: CHAN_HI_W];                            // R13
    digital_word[BYTE_W-1 -: CHAN_LO_W] = s_r.chan[CHAN_LO_W-1:0];
    sel_word = register_pick ? digital_word : result_word;       // R16
  end

  // multiplexer decode, one select line per input
  for (genvar i = 0; i < MUX_N; i++) begin : g_dec
    assign chan_hot[i] = (s_r.chan == CHAN_W'(i)) & CHAN_USED[i]; // R7
  end

  ////////////////////////////////////////////////////////////////////////
  // byte pointer, command capture, status and reset handling
  always_comb begin
    s_nxt        = s_r;
    s_nxt.bclk_q = bus_clk;
    s_nxt.start  = 1'b0;
    s_nxt.abort  = 1'b0;
    s_nxt.mux    = chan_hot;
    // pointer advances after the first access cycle, homes on idle
    if (bclk_fall && !cs_n)          s_nxt.ptr_lo = 1'b1;       // R15
    if ((bclk_rise && cs_n) || in_reset) s_nxt.ptr_lo = 1'b0;   // R15
    // bus is driven only in the high half of a read cycle
    s_nxt.doe  = rd_en & bus_clk;                                // R2
    s_nxt.dout = s_r.ptr_lo ? sel_word[BYTE_W-1:0]               // R3
                            : sel_word[2*BYTE_W-1:BYTE_W];       // R4
    // high command byte waits here until the low byte completes the word
    if (wr_en && !s_r.ptr_lo) s_nxt.wr_hi = data_in;
    if (wr_done) begin
      // only the trigger and the channel nibble are kept
      s_nxt.sc    = s_r.wr_hi[SC_BIT];                           // R5
      s_nxt.chan  = data_in[CHAN_LSB +: CHAN_W];                 // R19
      s_nxt.done  = 1'b0;                                        // R9
      s_nxt.start = s_r.wr_hi[SC_BIT];                           // R6 R17
    end
    // a finishing conversion wins over a clearing write
    if (core_done) begin
      s_nxt.done   = 1'b1;                                       // R8
      s_nxt.result = core_result;
    end
    // pin reset counts device clocks; result is left untouched
    if (!in_reset) s_nxt.rst_cnt = 2'h0;
    else if (bclk_rise && s_r.rst_cnt != RST_HOLD)
      s_nxt.rst_cnt = s_r.rst_cnt + 2'h1;
    if (in_reset && s_r.rst_cnt == RST_HOLD) begin
      s_nxt.sc    = 1'b0;                                        // R18
      s_nxt.abort = 1'b1;                                        // R18
      s_nxt.start = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) s_r <= '0;
    else      s_r <= s_nxt;
  end

  // converter core; start is a one-clk pulse, abort stays high while a counted pin reset lasts, both from the state flops
  ahpr_sar_core #(.ACQ(ACQ), .BITC(BITC)) u_core (
    .clk      (clk),
    .srst     (srst),
    .start    (s_r.start),
    .abort    (s_r.abort),
    .cmp_hi   (cmp_hi),
    .sampling (sampling),
    .busy     (core_busy),
    .done     (core_done),
    .result   (core_result),
    .trial    (trial_code)
  );

  // outputs leave straight from the state flops
  assign data_out = s_r.dout;
  assign data_oe  = s_r.doe;
  assign mux_sel  = s_r.mux;

  ////////////////////////////////////////////////////////////////////////
  // checks
  // all checks live in the system clock domain and pause under srst
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence wr_ms_s; wr_en && !s_r.ptr_lo; endsequence
  sequence wr_ls_trig_s; wr_done && s_r.wr_hi[SC_BIT]; endsequence
  sequence rd_hi_s; rd_en && bus_clk && !s_r.ptr_lo; endsequence
  sequence rd_lo_s; rd_en && bus_clk && s_r.ptr_lo; endsequence

  float_low_a: assert property (!bus_clk |=> !data_oe) // R2
    else $error("bus driven while device clock low");
  drive_read_a: assert property (rd_en && bus_clk |=> data_oe) // R2
    else $error("read cycle not driven");
  ms_first_a: assert property ( // R2
    rd_hi_s |=> data_out == $past(sel_word[2*BYTE_W-1:BYTE_W]))
    else $error("high byte not presented first");
  ls_next_a: assert property ( // R3
    rd_lo_s |=> data_out == $past(sel_word[BYTE_W-1:0]))
    else $error("low byte not presented after first cycle");
  ptr_home_a: assert property (bclk_rise && cs_n |=> !s_r.ptr_lo) // R15
    else $error("pointer not returned to high byte");
  start_conv_a: assert property (
    wr_ms_s ##[1:300] wr_ls_trig_s |=> s_r.start ##1 core_busy) // R6
    else $error("conversion not started after write");
  done_clear_a: assert property (wr_done && !core_done |=> !s_r.done) // R9
    else $error("done flag not cleared by write");
  done_set_a: assert property (
    core_done |=> s_r.done && s_r.result == $past(core_result)) // R8
    else $error("done flag or result not loaded");
  reset_keep_a: assert property (
    in_reset && s_r.rst_cnt == RST_HOLD |=>
      !data_oe && !s_r.sc && $stable(s_r.result) ##1 !core_busy) // R18
    else $error("pin reset did not idle and float");

  // read path details
  ptr_lo_a: assert property ( // R15
    bclk_fall && !cs_n && !in_reset |=> s_r.ptr_lo)
    else $error("pointer did not move to low byte");
  pin_view_a: assert property ( // R12
    rd_hi_s && register_pick |=>
      data_out[BYTE_W-1 -: PIN_N] == $past(shared_input_pins))
    else $error("shared pin levels not shown");
  chan_view_a: assert property ( // R13
    rd_lo_s && register_pick |=>
      data_out[BYTE_W-1 -: CHAN_LO_W] == s_r.chan[CHAN_LO_W-1:0])
    else $error("channel code not shown in low byte");
  result_zero_a: assert property ( // R10
    rd_hi_s && !register_pick |=> data_out[BYTE_W-1:DONE_BIT+1] == '0)
    else $error("unused result status bits not zero");
  result_low_a: assert property ( // R11
    rd_lo_s && !register_pick |=> data_out == $past(s_r.result))
    else $error("result byte not in low byte");

  // write path, converter and pin reset
  high_take_a: assert property ( // R4
    wr_ms_s |=> s_r.wr_hi == $past(data_in))
    else $error("high command byte not captured");
  chan_load_a: assert property ( // R19
    wr_done |=> s_r.chan == $past(data_in[CHAN_LSB +: CHAN_W]))
    else $error("channel field not loaded");
  no_trig_a: assert property ( // R6
    wr_done && !s_r.wr_hi[SC_BIT] |=> !s_r.start)
    else $error("conversion started without trigger bit");
  acquire_a: assert property (s_r.start |=> sampling) // R6 R17
    else $error("acquisition did not begin");
  mux_dark_a: assert property ( // R7
    $onehot0(mux_sel) && (mux_sel & ~CHAN_USED) == 16'h0)
    else $error("unused or multiple inputs selected");
  pin_reset_a: assert property (in_reset |=> !data_oe && !s_r.ptr_lo) // R18
    else $error("pin reset did not float the bus");
  done_keep_a: assert property ( // R18
    in_reset && !core_done |=> $stable(s_r.done))
    else $error("done flag lost in pin reset");
endmodule
`default_nettype wire

// *** include/ahpr_pkg.sv ***
package ahpr_pkg;
  localparam int BYTE_W       = 8;
  localparam int CHAN_W       = 4;
  localparam int PIN_N        = 6;
  localparam int MUX_N        = 16;
  // control word fields (bit 0 is the 2^-8 position of each byte)
  localparam int SC_BIT       = 0;    // in the high byte
  localparam int CHAN_LSB     = 0;    // in the low byte, msb at 2^-5
  // result word: done flag in the high byte, all other high bits zero
  localparam int DONE_BIT     = 0;
  // digital word: pins in high byte, channel split over both bytes
  localparam int PIN_LSB      = 2;
  localparam int CHAN_HI_W    = 2;
  localparam int CHAN_LO_W    = 2;
  // inputs wired to the multiplexer; 6..9 stay dark
  localparam logic [15:0] CHAN_USED = 16'hfc3f;
  // pin reset must be seen low for this many device clock rises
  localparam logic [1:0] RST_HOLD = 2'h3;
  // converter timing in system clock cycles
  localparam int ACQ_CYCLES   = 16;
  localparam int BIT_CYCLES   = 8;
  localparam logic [BYTE_W-1:0] TRIAL_MSB = 8'h80;

  typedef struct packed {
    logic              bclk_q;
    logic              ptr_lo;
    logic [BYTE_W-1:0] wr_hi;
    logic              sc;
    logic [CHAN_W-1:0] chan;
    logic              done;
    logic [BYTE_W-1:0] result;
    logic [BYTE_W-1:0] dout;
    logic              doe;
    logic [1:0]        rst_cnt;
    logic              start;
    logic              abort;
    logic [MUX_N-1:0]  mux;
  } ahpr_port_type;
endpackage

// *** verilog/ahpr_sar_core.sv ***
`timescale 1ns/10ps
`default_nettype none
module ahpr_sar_core #(
  parameter int ACQ = ahpr_pkg::ACQ_CYCLES,
  parameter int BITC = ahpr_pkg::BIT_CYCLES
) (
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic                        start,
  input  wire logic                        abort,
  input  wire logic                        cmp_hi,
  output logic                             sampling,
  output logic                             busy,
  output logic                             done,
  output logic [ahpr_pkg::BYTE_W-1:0]      result,
  output logic [ahpr_pkg::BYTE_W-1:0]      trial
);
  import ahpr_pkg::*;

  typedef enum logic [1:0] {IDLE, ACQUIRE, CONVERT} ahpr_st_type;
  typedef struct packed {
    ahpr_st_type       st;
    logic [15:0]       cnt;
    logic [2:0]        bitn;
    logic [BYTE_W-1:0] trial;
    logic [BYTE_W-1:0] result;
    logic              done;
    logic              samp;
  } ahpr_core_type;

  ahpr_core_type s_r, s_nxt;
  localparam logic [15:0] ACQ_LAST = 16'(ACQ - 1);
  localparam logic [15:0] BIT_LAST = 16'(BITC - 1);

  ////////////////////////////////////////////////////////////////////////
  // successive approximation: sample, then one trial bit per step
  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    unique case (s_r.st)
      IDLE: ;
      ACQUIRE: begin
        s_nxt.cnt = s_r.cnt + 16'h1;
        if (s_r.cnt == ACQ_LAST) begin
          s_nxt.st    = CONVERT;
          s_nxt.cnt   = 16'h0;
          s_nxt.bitn  = 3'h7;
          s_nxt.trial = TRIAL_MSB;
        end
      end
      CONVERT: begin
        s_nxt.cnt = s_r.cnt + 16'h1;
        if (s_r.cnt == BIT_LAST) begin
          s_nxt.cnt = 16'h0;
          // comparator low means the trial overshot the input
          if (!cmp_hi) s_nxt.trial[s_r.bitn] = 1'b0;
          if (s_r.bitn == 3'h0) begin
            s_nxt.st     = IDLE;
            s_nxt.done   = 1'b1;
            s_nxt.result = s_nxt.trial;
          end else begin
            s_nxt.trial[s_r.bitn - 3'h1] = 1'b1;
            s_nxt.bitn = s_r.bitn - 3'h1;
          end
        end
      end
    endcase
    // a fresh start restarts acquisition even mid conversion
    if (abort) s_nxt.st = IDLE;
    if (start) begin
      s_nxt.st  = ACQUIRE;
      s_nxt.cnt = 16'h0;
    end
    // registered so the sampling output leaves straight from a flop
    s_nxt.samp = (s_nxt.st == ACQUIRE);
  end

  always_ff @(posedge clk) begin
    if (srst) s_r <= '0;
    else      s_r <= s_nxt;
  end

  assign sampling = s_r.samp;
  assign busy     = (s_r.st != IDLE);
  assign done     = s_r.done;
  assign result   = s_r.result;
  assign trial    = s_r.trial;
endmodule
`default_nettype wire

// *** dv/ahpr_analog_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module ahpr_analog_model (
  input  wire logic [15:0] mux_sel,
  input  wire logic [7:0]  trial_code,
  input  wire logic [7:0]  level [16],
  output logic             cmp_hi
);
  // comparator; nothing selected reads as below every trial code
  always_comb begin
    cmp_hi = 1'h0;
    for (int i = 0; i < 16; i++) begin
      if (mux_sel[i] && level[i] >= trial_code) cmp_hi = 1'h1;
    end
  end
endmodule
`default_nettype wire

// *** dv/adc_host_port_registers_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module adc_host_port_registers_tb;
  import ahpr_pkg::*;
  logic        clk = 0;
  logic        srst = 1;
  logic        bus_clk = 0;
  logic        cs_n = 1;
  logic        rd_wr_n = 1;
  logic        register_pick = 0;
  logic        dev_reset_n = 1;
  logic        oe_q = 0;
  logic        cmp_hi, data_oe, sampling;
  logic [7:0]  data_in = 8'h00;
  logic [5:0]  pins = 6'h00;
  logic [7:0]  data_out, trial_code, prev;
  logic [15:0] mux_sel, e;
  logic [7:0]  level [16];
  logic [15:0] expq [$];
  logic [31:0] rs = 32'h60;
  logic [3:0]  ch;
  int          err_total = 0;
  int          checks_done = 0;
  int          samp_cycles = 0;
  ////////////////////////////////////////////////////////////////////////////
  ahpr_host_port #(.ACQ(2), .BITC(4)) ahpr_host_port_i (
    .clk(clk), .srst(srst), .bus_clk(bus_clk), .cs_n(cs_n),
    .rd_wr_n(rd_wr_n), .register_pick(register_pick),
    .dev_reset_n(dev_reset_n), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .shared_input_pins(pins), .cmp_hi(cmp_hi),
    .mux_sel(mux_sel), .sampling(sampling), .trial_code(trial_code));
  ahpr_analog_model ahpr_analog_model_i (
    .mux_sel(mux_sel), .trial_code(trial_code), .level(level),
    .cmp_hi(cmp_hi));
  ////////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic note(logic [7:0] mask, logic [7:0] val);
    expq.push_back({mask, val});
  endtask
  // one bus clock period, 3 clk high then 3 clk low, request held throughout
  task automatic bcyc(logic csn, logic wr, logic pick, logic [7:0] d);
    cs_n <= csn;
    rd_wr_n <= ~wr;
    register_pick <= pick;
    data_in <= d;
    bus_clk <= 1'h1;
    repeat (3) @(posedge clk);
    bus_clk <= 1'h0;
    repeat (3) @(posedge clk);
  endtask
  task automatic rd(logic pick, int n);
    repeat (n) bcyc(1'h0, 1'h0, pick, 8'h00);
    bcyc(1'h1, 1'h0, 1'h0, 8'h00);
  endtask
  // junk in the ignored bits must not disturb trigger or channel
  task automatic wcmd(logic sc);
    rs = xs(rs);
    bcyc(1'h0, 1'h1, 1'h0, {rs[7:1], sc});
    bcyc(1'h0, 1'h1, 1'h0, {rs[23:20], ch});
    bcyc(1'h1, 1'h0, 1'h0, 8'h00);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // each newly driven byte is matched against the oldest note
  always @(posedge clk) begin
    oe_q <= data_oe;
    if (sampling === 1'h1) samp_cycles <= samp_cycles + 1;
    if (data_oe === 1'h1 && oe_q !== 1'h1) begin
      // a drive with no note left always mismatches
      e = (expq.size() > 0) ? expq.pop_front() : 16'h00ff;
      chk("read byte", {8'h00, e[7:0]}, {8'h00, data_out & e[15:8]});
    end
  end
  // the whole run is near 2300 clk; this limit is far beyond it
  initial begin
    #100000;
    err_total++;
    end_of_test();
  end
  initial begin
    for (int i = 0; i < 16; i++) begin
      rs = xs(rs);
      level[i] = rs[7:0];
    end
    level[1] = 8'hff; // self-test input sits at full scale
    level[3] = ~level[2]; // abort test needs two distinct results
    prev = 8'h00;
    repeat (8) @(posedge clk);
    srst <= 1'h0;
    dev_reset_n <= 1'h0;
    repeat (3) bcyc(1'h1, 1'h0, 1'h0, 8'h00);
    dev_reset_n <= 1'h1;
    // every channel code; unused codes are written without trigger
    for (int c = 0; c < 16; c++) begin
      ch = 4'(c);
      wcmd(CHAN_USED[c]);
      chk("mux", CHAN_USED[c] ? 16'h1 << c : 16'h0, mux_sel);
      pins <= rs[13:8];
      repeat (60) @(posedge clk);
      if (CHAN_USED[c]) prev = level[c];
      note(8'hff, {7'h00, CHAN_USED[c]});
      note(8'hff, prev);
      rd(1'h0, 2);
      note(8'hff, {rs[13:8], ch[3:2]});
      note(8'hc0, {ch[1:0], 6'h00});
      note(8'hc0, {ch[1:0], 6'h00});
      rd(1'h1, 3);
      note(8'hff, {7'h00, CHAN_USED[c]});
      rd(1'h0, 1);
    end
    // second command lands while the first is still converting
    ch = 4'h2;
    wcmd(1'h1);
    ch = 4'h3;
    wcmd(1'h1);
    repeat (60) @(posedge clk);
    note(8'hff, 8'h01);
    note(8'hff, level[3]);
    rd(1'h0, 2);
    // reads during pin reset get no answer; result survives it
    dev_reset_n <= 1'h0;
    repeat (3) bcyc(1'h0, 1'h0, 1'h0, 8'h00);
    dev_reset_n <= 1'h1;
    bcyc(1'h1, 1'h0, 1'h0, 8'h00);
    note(8'hff, 8'h01);
    note(8'hff, level[3]);
    rd(1'h0, 2);
    repeat (10) @(posedge clk);
    chk("notes left", 16'h0, 16'(expq.size()));
    // 14 acquisitions of two clk: 12 used codes plus the abort pair
    chk("sampling clk", 16'h1c, 16'(samp_cycles));
    end_of_test();
  end
endmodule
`default_nettype wire
